//--- logic/pa_port.sv
// Contract
// - direction 1 floats the pin, direction 0 drives the latch value
// - data reads return pin states; writes only update the latch
// - each bit-op write samples pins, merges the change, stores into latch
// - bit 4 is open drain low only and feeds timer0 clock
// - bit 5 is input only, never driven
// - other bits are push-pull under their direction bits
// - comparator and vref control select pins; comparator inputs read 0
// - reset sets all inputs, disables digital inputs, grounds comparator inputs
// - oscillator-claimed bits 6,7 ignore direction and read 0
// - in output mode bits 3,4 carry comparator results if direction clear
// - in RC modes bit 6 may output clock at one quarter rate
// - in master reset mode bit 5 is an active low reset
// - an enabled peripheral owns its pin over general purpose use
// - unimplemented register bits read 0
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
module pa_port
  import pa_pkg::*;
(
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [11:0]   wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // port pins
  input  wire logic [7:0]    pin_in,
  output pa_pin_drive_t      pin_drive,
  // analog comparator side
  input  wire logic          comparator1_out,
  input  wire logic          comparator2_out,
  output logic      [7:0]    comparator_ctrl,
  output logic      [7:0]    analog_input_mask,
  output logic               comparator_inputs_grounded,
  // voltage reference side
  output logic      [7:0]    vref_ctrl,
  output logic               vref_output_enable,
  // alternate functions
  output logic               timer0_external_clock,
  output logic               master_reset_n,
  output logic               quarter_clock_out
);

  // registers
  logic [7:0]    latch_r;
  logic [7:0]    dir_r;
  logic [7:0]    cmp_r;
  logic [7:0]    vref_r;
  logic [7:0]    osc_r;
  pa_bus_state_t bus_r;
  logic [31:0]   rdat_r;
  logic [QCLK_DIV_W-1:0] div_r;
  logic          qclk_r;
  logic          mrst_n_r;
  logic          t0ck_r;

  // synchronised inputs
  logic [9:0]    sync_q;
  logic [7:0]    pin_s;
  logic          c1_s;
  logic          c2_s;

  // decoded state
  logic [9:0]    idx;
  logic          take;
  logic          wr;
  logic [7:0]    an_mask;
  logic [7:0]    claim;
  logic [7:0]    port_rd;
  logic [7:0]    cmp_rd;
  logic [2:0]    cm;
  logic          cmp_outs;
  logic          vref_oe;
  logic          mrst_en;
  logic          qclk_en;
  pa_osc_mode_t  osc_mode;
  logic [7:0]    rsel;
  pa_pin_drive_t drive_nxt;

  // analog pins for a comparator mode
  function automatic logic [7:0] analog_pins(input logic [2:0] mode);
    if (mode == CM_OFF) begin
      return AN_NONE;
    end else if (mode == CM_OUTPUTS) begin
      return AN_OUTMODE;
    end else begin
      return AN_ALL;
    end
  endfunction : analog_pins

  // pins taken by the oscillator
  function automatic logic [7:0] osc_claim(input pa_osc_mode_t mode,
                                           input logic ck_en);
    case (mode)
      OSC_CRYSTAL: return CLAIM_6 | CLAIM_7;
      OSC_EXT_CLK: return CLAIM_7;
      OSC_EXT_RC:  return CLAIM_7 | (ck_en ? CLAIM_6 : CLAIM_NONE);
      OSC_INT_RC:  return ck_en ? CLAIM_6 : CLAIM_NONE;
      default:     return CLAIM_NONE;
    endcase
  endfunction : osc_claim

  // pin state as software sees it
  function automatic logic [7:0] pin_view(input logic [7:0] pins,
                                          input logic [7:0] an,
                                          input logic [7:0] cl,
                                          input logic       mrst);
    logic [7:0] v;
    v = pins & ~an & ~cl;
    v[BIT_IN] = v[BIT_IN] & ~mrst;
    return v;
  endfunction : pin_view

  // pins and comparator results cross into ref_clk
  pa_sync #(
    .W(10)
  ) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .async_in({comparator2_out, comparator1_out, pin_in}),
    .sync_out(sync_q)
  );

  assign pin_s = sync_q[7:0];
  assign c1_s  = sync_q[8];
  assign c2_s  = sync_q[9];

  // field decode
  assign cm        = cmp_r[CMP_MODE_LSB +: 3];
  assign cmp_outs  = (cm == CM_OUTPUTS);
  assign vref_oe   = vref_r[VREF_EN_BIT] & vref_r[VREF_OE_BIT];
  assign mrst_en   = osc_r[OSC_MRST_BIT];
  assign qclk_en   = osc_r[OSC_QCLK_BIT];
  assign osc_mode  = pa_osc_mode_t'(osc_r[OSC_MODE_LSB +: 2]);

  assign an_mask = analog_pins(cm);
  assign claim   = osc_claim(osc_mode, qclk_en);

  assign port_rd = pin_view(pin_s, an_mask, claim, mrst_en);
  assign cmp_rd  = {c2_s, c1_s, cmp_r[5:0]};

  // bus decode
  assign idx  = wb_adr_i[11:2];
  assign take = (bus_r == BUS_IDLE) & wb_cyc_i & wb_stb_i;
  assign wr   = take & wb_we_i;

  // analog side controls
  assign comparator_ctrl   = cmp_r;
  assign vref_ctrl         = vref_r;

  // side outputs from flops; reset values match reset mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      analog_input_mask          <= AN_ALL;
      comparator_inputs_grounded <= 1'b1;
      vref_output_enable         <= 1'b0;
    end else begin
      analog_input_mask          <= an_mask;
      // reset mode grounds the comparator inputs
      comparator_inputs_grounded <= (cm == CM_RESET);
      vref_output_enable         <= vref_oe;
    end
  end

  // bus handshake: answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_r <= BUS_IDLE;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (wb_cyc_i & wb_stb_i) begin
            bus_r <= BUS_ACK;
          end
        end
        BUS_ACK: bus_r <= BUS_IDLE;
        default: bus_r <= BUS_IDLE;
      endcase
    end
  end

  assign wb_ack_o = (bus_r == BUS_ACK);

  // read mux; unmapped reads answer zero
  always_comb begin
    rsel = 8'h00;
    case (idx)
      IDX_PORT:  rsel = port_rd;
      IDX_CMP:   rsel = cmp_rd;
      IDX_DIR:   rsel = dir_r;
      IDX_VREF:  rsel = vref_r & VREF_MASK;
      IDX_OSC:   rsel = osc_r & OSC_MASK;
      IDX_BITOP: rsel = 8'h00;
      default:   rsel = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdat_r <= 32'h0000_0000;
    end else if (take) begin
      rdat_r <= {24'h00_0000, rsel};
    end
  end

  assign wb_dat_o = rdat_r;

  // output latch
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latch_r <= RST_LATCH;
    end else if (wr && idx == IDX_PORT) begin
      if (wb_sel_i[0]) begin
        latch_r <= wb_dat_i[7:0];
      end else begin
        latch_r <= port_rd;
      end
    end else if (wr && idx == IDX_BITOP && wb_sel_i[0]) begin
      // single bit merge on sampled pins
      latch_r <= port_rd;
      latch_r[wb_dat_i[BITOP_SEL_LSB +: 3]] <= wb_dat_i[BITOP_VAL_BIT];
    end
  end

  // direction register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dir_r <= RST_DIR;
    end else if (wr && idx == IDX_DIR && wb_sel_i[0]) begin
      dir_r <= wb_dat_i[7:0];
    end
  end

  // comparator control; result bits are read only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmp_r <= RST_CMP;
    end else if (wr && idx == IDX_CMP && wb_sel_i[0]) begin
      cmp_r <= wb_dat_i[7:0] & CMP_RW_MASK;
    end
  end

  // voltage reference control
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vref_r <= RST_VREF;
    end else if (wr && idx == IDX_VREF && wb_sel_i[0]) begin
      vref_r <= wb_dat_i[7:0] & VREF_MASK;
    end
  end

  // oscillator configuration
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      osc_r <= RST_OSC;
    end else if (wr && idx == IDX_OSC && wb_sel_i[0]) begin
      osc_r <= wb_dat_i[7:0] & OSC_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_r  <= '0;
      qclk_r <= 1'b0;
    end else begin
      div_r  <= div_r + 1'b1;
      qclk_r <= div_r[QCLK_DIV_W-1];
    end
  end

  assign quarter_clock_out = qclk_r;

  // alternate inputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mrst_n_r <= 1'b1;
      t0ck_r   <= 1'b0;
    end else begin
      // bit 5 as active low reset
      mrst_n_r <= mrst_en ? pin_s[BIT_IN] : 1'b1;
      t0ck_r   <= pin_s[BIT_OD];
    end
  end

  assign master_reset_n        = mrst_n_r;
  assign timer0_external_clock = t0ck_r;

  // pin drivers; oe_n low means driving
  always_comb begin
    drive_nxt.out  = latch_r;
    drive_nxt.oe_n = dir_r;

    // comparator 1 result on bit 3
    if (cmp_outs) begin
      drive_nxt.out[BIT_C1] = c1_s;
    end

    // vref owns bit 2 when enabled
    if (vref_oe) begin
      drive_nxt.oe_n[BIT_VREF] = 1'b1;
    end

    drive_nxt.out[BIT_OD] = 1'b0;
    if (cmp_outs) begin
      // comparator 2 result on bit 4
      drive_nxt.oe_n[BIT_OD] = dir_r[BIT_OD] | c2_s;
    end else begin
      drive_nxt.oe_n[BIT_OD] = dir_r[BIT_OD] | latch_r[BIT_OD];
    end

    drive_nxt.out[BIT_IN]  = 1'b0;
    drive_nxt.oe_n[BIT_IN] = 1'b1;

    if (claim[BIT_QCLK]) begin
      if (qclk_en && (osc_mode == OSC_EXT_RC || osc_mode == OSC_INT_RC)) begin
        // quarter clock out on bit 6
        drive_nxt.out[BIT_QCLK]  = qclk_r;
        drive_nxt.oe_n[BIT_QCLK] = 1'b0;
      end else begin
        drive_nxt.out[BIT_QCLK]  = 1'b0;
        drive_nxt.oe_n[BIT_QCLK] = 1'b1;
      end
    end
    if (claim[BIT_OSC_IN]) begin
      drive_nxt.out[BIT_OSC_IN]  = 1'b0;
      drive_nxt.oe_n[BIT_OSC_IN] = 1'b1;
    end
  end

  // pins driven from a flop, so decode glitches never reach the board
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_drive <= '{out: RST_LATCH, oe_n: RST_DIR};
    end else begin
      pin_drive <= drive_nxt;
    end
  end

endmodule : pa_port

//--- pkg/pa_pkg.sv
package pa_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_PORT  = 10'h005;
  localparam logic [9:0] IDX_CMP   = 10'h01f;
  localparam logic [9:0] IDX_DIR   = 10'h085;
  localparam logic [9:0] IDX_VREF  = 10'h09f;
  localparam logic [9:0] IDX_OSC   = 10'h0a0;
  localparam logic [9:0] IDX_BITOP = 10'h0a1;

  // reset values
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'hff;
  localparam logic [7:0] RST_CMP   = 8'h00;
  localparam logic [7:0] RST_VREF  = 8'h00;
  localparam logic [7:0] RST_OSC   = 8'h00;

  // comparator control fields
  localparam int         CMP_MODE_LSB = 0;
  localparam int         CMP_C1_BIT   = 6;
  localparam int         CMP_C2_BIT   = 7;
  localparam logic [7:0] CMP_RW_MASK  = 8'h3f;
  localparam logic [2:0] CM_RESET     = 3'h0;
  localparam logic [2:0] CM_OUTPUTS   = 3'h6;
  localparam logic [2:0] CM_OFF       = 3'h7;

  // voltage reference control fields
  localparam int         VREF_EN_BIT = 7;
  localparam int         VREF_OE_BIT = 6;
  localparam logic [7:0] VREF_MASK   = 8'hef;

  // oscillator configuration fields
  localparam int         OSC_MODE_LSB   = 0;
  localparam int         OSC_QCLK_BIT   = 2;
  localparam int         OSC_MRST_BIT   = 3;
  localparam logic [7:0] OSC_MASK       = 8'h0f;

  // single-bit read-modify-write fields
  localparam int BITOP_SEL_LSB = 0;
  localparam int BITOP_VAL_BIT = 3;

  // pin positions
  localparam int BIT_VREF   = 2;
  localparam int BIT_C1     = 3;
  localparam int BIT_OD     = 4;
  localparam int BIT_IN     = 5;
  localparam int BIT_QCLK   = 6;
  localparam int BIT_OSC_IN = 7;

  // analog pin masks per comparator mode
  localparam logic [7:0] AN_NONE    = 8'h00;
  localparam logic [7:0] AN_OUTMODE = 8'h07;
  localparam logic [7:0] AN_ALL     = 8'h0f;

  // oscillator pin claims
  localparam logic [7:0] CLAIM_NONE = 8'h00;
  localparam logic [7:0] CLAIM_6    = 8'h40;
  localparam logic [7:0] CLAIM_7    = 8'h80;

  // quarter clock divider width (divide by four)
  localparam int QCLK_DIV_W = 2;

  typedef enum logic [1:0] {
    OSC_INT_RC,
    OSC_EXT_RC,
    OSC_EXT_CLK,
    OSC_CRYSTAL
  } pa_osc_mode_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } pa_bus_state_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pa_pin_drive_t;

endpackage : pa_pkg

//--- logic/pa_sync.sv
`timescale 1ns/1ns
module pa_sync #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // async in, synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : pa_sync

//--- testbench/pa_checker.sv
`timescale 1ns/1ns
module pa_checker
  import pa_pkg::*;
(
  // clock and reset
  input wire logic          ref_clk,
  input wire logic          sys_rst,
  // bus
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  // pins and side outputs
  input wire pa_pin_drive_t pin_drive,
  input wire logic [7:0]    comparator_ctrl,
  input wire logic [7:0]    analog_input_mask,
  input wire logic          comparator_inputs_grounded,
  input wire logic [7:0]    vref_ctrl,
  input wire logic          vref_output_enable,
  input wire logic          quarter_clock_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] mode;
  assign mode = comparator_ctrl[2:0];
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  reset_state_a: assert property ($past(sys_rst) |->
    pin_drive.oe_n == 8'hff && analog_input_mask == AN_ALL && comparator_inputs_grounded)
    else $error("state after reset wrong");
  bit5_float_a: assert property (pin_drive.oe_n[BIT_IN])
    else $error("input only pin driven");
  od_low_a: assert property (!pin_drive.oe_n[BIT_OD] |-> !pin_drive.out[BIT_OD])
    else $error("open drain pin driven high");
  mask_mode_a: assert property ($stable(mode) |-> analog_input_mask ==
    (mode == CM_OFF ? AN_NONE : (mode == CM_OUTPUTS ? AN_OUTMODE : AN_ALL)))
    else $error("analog mask does not follow mode");
  ground_mode_a: assert property ($stable(mode) |->
    comparator_inputs_grounded == (mode == CM_RESET))
    else $error("grounding does not follow mode");
  unused_zero_a: assert property (vref_ctrl[4] == 1'h0 && comparator_ctrl[7:6] == 2'h0)
    else $error("unimplemented bit set");
  vref_pin_a: assert property (vref_output_enable |-> pin_drive.oe_n[BIT_VREF])
    else $error("reference pin driven digitally");
  quarter_clk_a: assert property ($rose(quarter_clock_out) |=>
    quarter_clock_out ##1 !quarter_clock_out [*2] ##1 quarter_clock_out)
    else $error("quarter clock period wrong");
  cover property (wb_ack_o);
  cover property (mode == CM_OUTPUTS && !pin_drive.oe_n[BIT_C1]);
  cover property (vref_output_enable);
endmodule : pa_checker

//--- testbench/pa_board.sv
`timescale 1ns/1ns
module pa_board
  import pa_pkg::*;
(
  // design drive
  input wire pa_pin_drive_t pin_drive,
  // bench drive
  input wire logic [7:0]    ext_val,
  input wire logic [7:0]    ext_en,
  // resolved levels
  output logic [7:0]        pin_in
);
  // pull-ups on board
  // every pin has a pull-up, so a released line reads 1, never a stale value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_drive.oe_n[i] ? pin_drive.out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
    end
  end
endmodule : pa_board

//--- testbench/pa_port_tb.sv
`timescale 1ns/1ns
module pa_port_tb;
  import pa_pkg::*;
  typedef struct packed {logic [9:0] a; logic [7:0] d; logic [7:0] e;} pa_row_t;
  logic          ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic          comparator1_out, comparator2_out, comparator_inputs_grounded;
  logic          vref_output_enable, timer0_external_clock, master_reset_n, quarter_clock_out;
  logic [11:0]   wb_adr_i;
  logic [3:0]    wb_sel_i;
  logic [31:0]   wb_dat_i, wb_dat_o;
  logic [7:0]    pin_in, ext_val, ext_en, rd, e;
  logic [7:0]    comparator_ctrl, analog_input_mask, vref_ctrl;
  pa_pin_drive_t pin_drive;
  int            bad_count, n_compared;
  pa_row_t       rows [6] = '{'{IDX_CMP, 8'hff, 8'h3f}, '{IDX_VREF, 8'hff, 8'hef},
    '{IDX_OSC, 8'hff, 8'h0f}, '{IDX_DIR, 8'ha5, 8'ha5}, '{10'h000, 8'hff, 8'h00},
    '{IDX_BITOP, 8'h07, 8'h00}};
  // osc cfg, port read, oe_n (in a) with direction 3f and latch 43
  pa_row_t       oscs [6] = '{'{10'h03f, 8'h00, 8'h7f}, '{10'h0bf, 8'h01, 8'h7f},
    '{10'h0bf, 8'h02, 8'h7f}, '{10'h0ff, 8'h03, 8'h3f}, '{10'h03f, 8'h04, 8'h3f},
    '{10'h0bf, 8'h05, 8'h3f}};
  pa_port  uut (.*);
  pa_board brd (.*);
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic [9:0] a, input logic w, input logic [3:0] s,
                    input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= {a, 2'h0};
    wb_sel_i <= s;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n == 20) begin
      bad_count++;
      tally_and_finish();
    end
    @(posedge ref_clk);
  endtask : wb
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    wb(a, 1'h1, 4'h1, d);
  endtask : wr
  task automatic rc(input logic [9:0] a, input logic [7:0] x);
    wb(a, 1'h0, 4'h1, 8'h00);
    chk(rd, x);
  endtask : rc
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  initial begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, comparator1_out, comparator2_out} = 6'h20;
    {wb_adr_i, wb_sel_i, wb_dat_i, ext_val, ext_en} = '0;
    tick(12);
    sys_rst <= 1'h0;
    rc(IDX_DIR, 8'hff);
    rc(IDX_PORT, 8'hf0);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rc(rows[k].a, rows[k].e);
    end
    wr(IDX_OSC, 8'h00);
    wr(IDX_VREF, 8'h00);
    wr(IDX_CMP, {5'h00, CM_OFF});
    wr(IDX_DIR, 8'h00);
    wr(IDX_PORT, 8'h5a);
    tick(3);
    chk(pin_drive.oe_n, 8'h30);
    rc(IDX_PORT, 8'h7a);
    wr(IDX_PORT, 8'hef);
    tick(3);
    chk(pin_drive.oe_n, 8'h20);
    rc(IDX_PORT, 8'hef);
    wr(IDX_DIR, 8'hff);
    {ext_val, ext_en} <= 16'hc3ff;
    wr(IDX_PORT, 8'h00);
    tick(3);
    rc(IDX_PORT, 8'hc3);
    ext_en <= 8'h00;
    wr(IDX_DIR, 8'h00);
    tick(3);
    rc(IDX_PORT, 8'h20);
    wr(IDX_DIR, 8'hff);
    {ext_val, ext_en} <= 16'h42ff;
    tick(3);
    wb(IDX_PORT, 1'h1, 4'h0, 8'h00);
    wr(IDX_BITOP, 8'h08);
    ext_en <= 8'h00;
    wr(IDX_DIR, 8'h00);
    tick(3);
    rc(IDX_PORT, 8'h63);
    wr(IDX_DIR, 8'hff);
    {ext_val, ext_en} <= 16'hffff;
    for (int m = 0; m < 8; m++) begin
      e = (m == 7) ? AN_NONE : ((m == 6) ? AN_OUTMODE : AN_ALL);
      wr(IDX_CMP, 8'(m));
      tick(2);
      chk(analog_input_mask, e);
      chk({7'h00, comparator_inputs_grounded}, {7'h00, m == 0});
      rc(IDX_PORT, ~e);
    end
    wr(IDX_CMP, {5'h00, CM_OFF});
    wr(IDX_DIR, 8'h3f);
    ext_en <= 8'h3f;
    foreach (oscs[k]) begin
      wr(IDX_OSC, oscs[k].d);
      tick(3);
      chk(pin_drive.oe_n, oscs[k].a[7:0]);
      rc(IDX_PORT, oscs[k].e);
    end
    wr(IDX_OSC, 8'h08);
    tick(3);
    rc(IDX_PORT, 8'h5f);
    ext_val <= 8'hdf;
    tick(4);
    chk({7'h00, master_reset_n}, 8'h00);
    wr(IDX_OSC, 8'h00);
    chk({7'h00, master_reset_n}, 8'h01);
    ext_val <= 8'hef;
    wr(IDX_DIR, 8'hff);
    tick(4);
    chk({7'h00, timer0_external_clock}, 8'h00);
    ext_val <= 8'hff;
    tick(4);
    chk({7'h00, timer0_external_clock}, 8'h01);
    wr(IDX_DIR, 8'h00);
    ext_en <= 8'h00;
    comparator1_out <= 1'h1;
    wr(IDX_CMP, {5'h00, CM_OUTPUTS});
    tick(4);
    rc(IDX_PORT, 8'h68);
    {comparator1_out, comparator2_out} <= 2'h1;
    tick(5);
    rc(IDX_PORT, 8'h70);
    wr(IDX_VREF, 8'hc0);
    tick(2);
    chk({7'h00, pin_drive.oe_n[BIT_VREF]}, 8'h01);
    wr(IDX_DIR, 8'h04);
    sys_rst <= 1'h1;
    tick(3);
    sys_rst <= 1'h0;
    rc(IDX_DIR, 8'hff);
    tally_and_finish();
  end
endmodule : pa_port_tb
bind pa_port pa_checker chk_i (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .pin_drive, .comparator_ctrl, .analog_input_mask, .comparator_inputs_grounded,
  .vref_ctrl, .vref_output_enable, .quarter_clock_out);
